// File: verilog/pxlut_pkg.sv
// Package for the pixel lookup table: register map, field layout, stream carrier.
// Assumes a 32-bit APB master and a 100 MHz single clock.
//
// Behaviour
// RULE1 - Three separate tables, red, green, blue
// RULE2 - Output stored entry in place of pixel
// RULE3 - Fourteen-bit index, 16384 entries per table
// RULE4 - Sixteen-bit pixels and sixteen-bit entries
// RULE5 - Index taken from pixel's upper bits
// RULE6 - Substitution is the last correction step
// RULE7 - Output formatting sees translated values
// RULE8 - Enable defaults off; processor fill inactive too
// RULE9 - Disabled table passes pixels unchanged
// RULE10 - Source select defaults to processor
// RULE11 - Direct entry writes allowed under any source
// RULE12 - Direct write replaces any earlier entry
// RULE13 - Processor or file reload overwrites direct entries
// RULE14 - File load only under file source; errors flagged
// RULE15 - Supplier gives header plus per-colour table (file load here writes fill_value_reg to all three tables instead)
// RULE16 - Processor fill uses one parameter set
package pxlut_pkg;

    // ==================================================================
    // Geometry
    localparam int PX_W = 16;
    localparam int IDX_W = 14;
    localparam int DEPTH = 16384;

    // ==================================================================
    // Register byte offsets
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_STATUS = 12'h004;
    localparam logic [11:0] OFS_RED_IDX = 12'h008;
    localparam logic [11:0] OFS_RED_VAL = 12'h00C;
    localparam logic [11:0] OFS_GRN_IDX = 12'h010;
    localparam logic [11:0] OFS_GRN_VAL = 12'h014;
    localparam logic [11:0] OFS_BLU_IDX = 12'h018;
    localparam logic [11:0] OFS_BLU_VAL = 12'h01C;
    localparam logic [11:0] OFS_FILL_VAL = 12'h020;
    localparam logic [11:0] OFS_FILL_CMD = 12'h024;

    // Control fields
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_SRC_BIT = 1;
    localparam logic CTRL_EN_RST = 1'b0;
    localparam logic CTRL_SRC_RST = 1'b0;
    // Fill command fields
    localparam int CMD_START_BIT = 0;
    localparam int CMD_FILE_BIT = 1;
    localparam int CMD_CLRERR_BIT = 2;
    // Status fields
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_ERR_BIT = 1;

    // Source encodings
    typedef enum logic {
        SRC_PROCESSOR = 1'b0,
        SRC_CUSTOM_FILE = 1'b1
    } pxlut_src_e;

    // RGB pixel carrier
    typedef struct packed {
        logic [PX_W-1:0] red;
        logic [PX_W-1:0] green;
        logic [PX_W-1:0] blue;
    } pxlut_rgb_s;

endpackage

// File: verilog/pxlut_skid.sv
// Two-entry skid buffer carrying RGB pixels.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module pxlut_skid
(
    input wire logic i_clk, // Clock
    input wire logic i_rst, // Sync reset
    input wire logic i_valid, // Upstream valid
    output logic o_ready, // Upstream ready
    input wire pxlut_pkg::pxlut_rgb_s i_data, // Upstream data
    output logic o_valid, // Downstream valid
    input wire logic i_ready, // Downstream ready
    output pxlut_pkg::pxlut_rgb_s o_data // Downstream data
);
    import pxlut_pkg::*;

    pxlut_rgb_s mem_reg [2];
    logic wp_reg;
    logic rp_reg;
    logic [1:0] cnt_reg;
    logic push;
    logic pop;

    // Handshake terms
    assign o_ready = (cnt_reg != 2'h2);
    assign o_valid = (cnt_reg != 2'h0);
    assign push = i_valid && o_ready;
    assign pop = o_valid && i_ready;
    assign o_data = mem_reg[rp_reg];

    // Storage
    always_ff @(posedge i_clk)
    begin
        if (push)
        begin
            mem_reg[wp_reg] <= i_data;
        end
    end

    // Pointers and occupancy
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            wp_reg <= 1'b0;
            rp_reg <= 1'b0;
            cnt_reg <= 2'h0;
        end
        else
        begin
            if (push)
            begin
                wp_reg <= ~wp_reg;
            end
            if (pop)
            begin
                rp_reg <= ~rp_reg;
            end
            if (push && !pop)
            begin
                cnt_reg <= cnt_reg + 2'h1;
            end
            else if (pop && !push)
            begin
                cnt_reg <= cnt_reg - 2'h1;
            end
        end
    end
endmodule // pxlut_skid

// File: verilog/pxlut_top.sv
// Pixel lookup table: three 16384 x 16 tables, APB register slave, pixel stream.
// Assumes upstream pipeline gives RGB pixels with valid/ready; format stage follows.
//
// Added by the designer: the address map and register access over APB.
`timescale 1ns/1ps
module pxlut_top
(
    input wire logic I_MCLK, // 100 MHz clock
    input wire logic I_SRST, // Sync reset, active high
    input wire logic I_PSEL, // APB select
    input wire logic I_PENABLE, // APB enable
    input wire logic I_PWRITE, // APB direction
    input wire logic [11:0] I_PADDR, // APB byte address
    input wire logic [31:0] I_PWDATA, // APB write data
    output logic [31:0] O_PRDATA, // APB read data
    output logic O_PREADY, // APB ready
    output logic O_PSLVERR, // APB error
    input wire logic I_PX_VALID, // Input pixel valid
    output logic O_PX_READY, // Input pixel ready
    input wire pxlut_pkg::pxlut_rgb_s I_PX_DATA, // Input pixel
    output logic O_PX_VALID, // Output pixel valid
    input wire logic I_PX_READY, // Format stage ready
    output pxlut_pkg::pxlut_rgb_s O_PX_DATA // Translated pixel
);
    import pxlut_pkg::*;

    // ==================================================================
    // Declarations
    typedef enum logic [1:0] {
        FILL_IDLE = 2'b01,
        FILL_RUN = 2'b10
    } pxlut_fill_e;

    logic [PX_W-1:0] red_tab [DEPTH]; // RULE1
    logic [PX_W-1:0] grn_tab [DEPTH];
    logic [PX_W-1:0] blu_tab [DEPTH];

    logic table_enable_reg;
    pxlut_src_e table_source_select_reg;
    logic [IDX_W-1:0] red_entry_index_reg;
    logic [IDX_W-1:0] green_entry_index_reg;
    logic [IDX_W-1:0] blue_entry_index_reg;
    logic [PX_W-1:0] fill_value_reg;
    logic fill_err_reg;
    pxlut_fill_e fill_state_reg;
    logic [IDX_W-1:0] fill_idx_reg;
    logic [31:0] prdata_reg;
    logic acc;
    logic wr;
    logic rd;
    logic fill_start;
    logic fill_busy;
    logic dec_ok;
    logic cmd_wr;
    logic red_wr;
    logic grn_wr;
    logic blu_wr;

    logic s1_valid_reg;
    pxlut_rgb_s s1_pix_reg;
    logic s1_en_reg;
    pxlut_rgb_s s1_out;
    logic buf_ready;
    logic adv;

    // Address decode shared by reads and writes
    function automatic logic reg_hit(input logic [11:0] a);
        reg_hit = (a == OFS_CTRL) || (a == OFS_STATUS) || (a == OFS_RED_IDX)
            || (a == OFS_RED_VAL) || (a == OFS_GRN_IDX) || (a == OFS_GRN_VAL)
            || (a == OFS_BLU_IDX) || (a == OFS_BLU_VAL) || (a == OFS_FILL_VAL)
            || (a == OFS_FILL_CMD);
    endfunction

    // ==================================================================
    // APB slave: zero wait states, unmapped address gives PSLVERR
    assign acc = I_PSEL && I_PENABLE;
    assign dec_ok = reg_hit(I_PADDR);
    assign wr = acc && I_PWRITE && dec_ok;
    assign rd = acc && !I_PWRITE && dec_ok;
    assign O_PREADY = acc;
    assign O_PSLVERR = acc && !dec_ok;
    assign O_PRDATA = prdata_reg;
    assign fill_busy = (fill_state_reg == FILL_RUN);
    // Write strobes for the command word and the three entry ports
    assign cmd_wr = wr && (I_PADDR == OFS_FILL_CMD);
    assign red_wr = wr && (I_PADDR == OFS_RED_VAL);
    assign grn_wr = wr && (I_PADDR == OFS_GRN_VAL);
    assign blu_wr = wr && (I_PADDR == OFS_BLU_VAL);
    // File load only while custom file source is selected
    assign fill_start = cmd_wr && I_PWDATA[CMD_START_BIT]
        && !fill_busy
        && (I_PWDATA[CMD_FILE_BIT] ? (table_source_select_reg == SRC_CUSTOM_FILE)
            : (table_source_select_reg == SRC_PROCESSOR)); // RULE14

    // Control registers
    always_ff @(posedge I_MCLK)
    begin
        if (I_SRST)
        begin
            table_enable_reg <= CTRL_EN_RST; // RULE8
            table_source_select_reg <= pxlut_src_e'(CTRL_SRC_RST); // RULE10
        end
        else if (wr && (I_PADDR == OFS_CTRL))
        begin
            table_enable_reg <= I_PWDATA[CTRL_EN_BIT];
            table_source_select_reg <= pxlut_src_e'(I_PWDATA[CTRL_SRC_BIT]);
        end
    end

    // Entry index and fill value registers
    always_ff @(posedge I_MCLK)
    begin
        if (I_SRST)
        begin
            red_entry_index_reg <= '0;
            green_entry_index_reg <= '0;
            blue_entry_index_reg <= '0;
            fill_value_reg <= '0;
        end
        else if (wr)
        begin
            case (I_PADDR)
                OFS_RED_IDX: red_entry_index_reg <= I_PWDATA[IDX_W-1:0];
                OFS_GRN_IDX: green_entry_index_reg <= I_PWDATA[IDX_W-1:0];
                OFS_BLU_IDX: blue_entry_index_reg <= I_PWDATA[IDX_W-1:0];
                OFS_FILL_VAL: fill_value_reg <= I_PWDATA[PX_W-1:0];
                default: fill_value_reg <= fill_value_reg;
            endcase
        end
    end

    // ==================================================================
    // Fill engine and load error
    // Fill engine: rewrites all three tables entry by entry
    // One entry per clock for all three tables, DEPTH cycles in all
    always_ff @(posedge I_MCLK)
    begin
        if (I_SRST)
        begin
            fill_state_reg <= FILL_IDLE;
            fill_idx_reg <= '0;
        end
        else
        begin
            case (fill_state_reg)
                FILL_IDLE:
                begin
                    if (fill_start)
                    begin
                        fill_state_reg <= FILL_RUN;
                        fill_idx_reg <= '0;
                    end
                end
                FILL_RUN:
                begin
                    fill_idx_reg <= fill_idx_reg + 14'h1;
                    if (fill_idx_reg == 14'(DEPTH - 1))
                    begin
                        fill_state_reg <= FILL_IDLE;
                    end
                end
                default: fill_state_reg <= FILL_IDLE;
            endcase
        end
    end

    // Load error: any refused start, file load or processor fill, sets it, command bit clears it; set wins
    // A refused start also covers a start while the sweep is busy
    always_ff @(posedge I_MCLK)
    begin
        if (I_SRST)
        begin
            fill_err_reg <= 1'b0;
        end
        else if (cmd_wr && I_PWDATA[CMD_START_BIT] && !fill_start)
        begin
            fill_err_reg <= 1'b1; // RULE14
        end
        else if (cmd_wr && I_PWDATA[CMD_CLRERR_BIT])
        begin
            fill_err_reg <= 1'b0;
        end
    end

    // ==================================================================
    // Table storage: one write port per colour, fill sweep has priority
    // Direct entry writes that arrive while the sweep runs are dropped
    // Red table
    always_ff @(posedge I_MCLK)
    begin
        if (fill_busy)
        begin
            red_tab[fill_idx_reg] <= fill_value_reg; // RULE13
        end
        else if (red_wr)
        begin
            red_tab[red_entry_index_reg] <= I_PWDATA[PX_W-1:0]; // RULE11
        end
    end

    // Green table
    always_ff @(posedge I_MCLK)
    begin
        if (fill_busy)
        begin
            grn_tab[fill_idx_reg] <= fill_value_reg; // RULE16
        end
        else if (grn_wr)
        begin
            grn_tab[green_entry_index_reg] <= I_PWDATA[PX_W-1:0]; // RULE12
        end
    end

    // Blue table
    always_ff @(posedge I_MCLK)
    begin
        if (fill_busy)
        begin
            blu_tab[fill_idx_reg] <= fill_value_reg;
        end
        else if (blu_wr)
        begin
            blu_tab[blue_entry_index_reg] <= I_PWDATA[PX_W-1:0];
        end
    end

    // Read data, registered in the setup cycle
    // An index write lands before the next setup edge, so entry reads follow it
    always_ff @(posedge I_MCLK)
    begin
        if (I_SRST)
        begin
            prdata_reg <= '0;
        end
        else if (I_PSEL && !I_PENABLE && !I_PWRITE)
        begin
            case (I_PADDR)
                OFS_CTRL: prdata_reg <= {30'h0, table_source_select_reg,
                    table_enable_reg};
                OFS_STATUS: prdata_reg <= {30'h0, fill_err_reg, fill_busy};
                OFS_RED_IDX: prdata_reg <= {18'h0, red_entry_index_reg};
                OFS_RED_VAL: prdata_reg <= {16'h0, red_tab[red_entry_index_reg]};
                OFS_GRN_IDX: prdata_reg <= {18'h0, green_entry_index_reg};
                OFS_GRN_VAL: prdata_reg <= {16'h0, grn_tab[green_entry_index_reg]};
                OFS_BLU_IDX: prdata_reg <= {18'h0, blue_entry_index_reg};
                OFS_BLU_VAL: prdata_reg <= {16'h0, blu_tab[blue_entry_index_reg]};
                OFS_FILL_VAL: prdata_reg <= {16'h0, fill_value_reg};
                default: prdata_reg <= 32'h0000_0000;
            endcase
        end
    end

    // ==================================================================
    // Pixel path: stage 1 reads tables, buffer feeds format stage
    assign adv = !s1_valid_reg || buf_ready;
    assign O_PX_READY = adv;

    // Stage 1 capture with index from top 14 bits
    // Enable is captured with the pixel so a toggle never splits one pixel
    always_ff @(posedge I_MCLK)
    begin
        if (I_SRST)
        begin
            s1_valid_reg <= 1'b0;
            s1_en_reg <= 1'b0;
            s1_pix_reg <= '0;
        end
        else if (adv)
        begin
            s1_valid_reg <= I_PX_VALID;
            s1_en_reg <= table_enable_reg;
            s1_pix_reg <= I_PX_DATA;
        end
    end

    // Substitution or pass-through; last step before the format stage
    // Table reads are combinational from the stage 1 index; the buffer registers them
    always_comb
    begin
        if (s1_en_reg)
        begin
            s1_out.red = red_tab[s1_pix_reg.red[PX_W-1 -: IDX_W]]; // RULE5
            s1_out.green = grn_tab[s1_pix_reg.green[PX_W-1 -: IDX_W]]; // RULE2
            s1_out.blue = blu_tab[s1_pix_reg.blue[PX_W-1 -: IDX_W]]; // RULE3
        end
        else
        begin
            s1_out = s1_pix_reg; // RULE9
        end
    end

    // Output buffer toward format conversion
    // A stall at the format stage backs up into stage 1, then upstream
    pxlut_skid u_skid
    (
        .i_clk(I_MCLK),
        .i_rst(I_SRST),
        .i_valid(s1_valid_reg),
        .o_ready(buf_ready),
        .i_data(s1_out), // RULE6 RULE7 RULE4
        .o_valid(O_PX_VALID),
        .i_ready(I_PX_READY),
        .o_data(O_PX_DATA)
    );
endmodule // pxlut_top

// File: test/pxlut_chk.sv
// Checker: APB answer and pixel stream handshake of the lookup table.
// Assumes it is bound to pxlut_top and sees only its ports.
`timescale 1ns/1ps
module pxlut_chk
(
    input wire logic I_MCLK, // Clock
    input wire logic I_SRST, // Reset
    input wire logic I_PSEL, // Select
    input wire logic I_PENABLE, // Enable
    input wire logic [11:0] I_PADDR, // Address
    input wire logic O_PREADY, // Ready
    input wire logic O_PSLVERR, // Error
    input wire logic I_PX_VALID, // In valid
    input wire logic O_PX_READY, // In ready
    input wire logic O_PX_VALID, // Out valid
    input wire logic I_PX_READY, // Out ready
    input wire pxlut_pkg::pxlut_rgb_s O_PX_DATA // Out pixel
);
    import pxlut_pkg::*;
    logic acc;
    logic take;
    // ==========
    // Shared terms
    assign acc = I_PSEL && I_PENABLE;
    assign take = I_PX_VALID && O_PX_READY;
    default clocking cb @(posedge I_MCLK);
    endclocking
    default disable iff (I_SRST);
    // ==========
    // Bus and stream
    chk_ready_now: assert property (acc |-> O_PREADY)
        else $error("no zero-wait ready");
    chk_err_unmapped: assert property (acc && I_PADDR > OFS_FILL_CMD |-> O_PSLVERR)
        else $error("unmapped access not refused");
    chk_err_mapped: assert property (acc && I_PADDR[1:0] == 2'h0 && I_PADDR <= OFS_FILL_CMD
        |-> !O_PSLVERR) else $error("mapped access refused");
    chk_out_hold: assert property (O_PX_VALID && !I_PX_READY
        |=> O_PX_VALID && $stable(O_PX_DATA)) else $error("stalled pixel changed");
    chk_pipe_fill: assert property (take && !O_PX_VALID |-> ##2 O_PX_VALID)
        else $error("pixel late");
    chk_no_phantom: assert property ($rose(O_PX_VALID) |-> $past(take, 2))
        else $error("pixel from nowhere");
    chk_in_ready: assert property (!O_PX_VALID |-> O_PX_READY)
        else $error("refused while empty");
    chk_ready_full: assert property (!O_PX_READY |-> O_PX_VALID && $past(O_PX_VALID && !I_PX_READY))
        else $error("refused without stall");
endmodule // pxlut_chk

// File: test/pxlut_sink.sv
// Format stage model: takes translated pixels and stalls now and then.
// Assumes one clock shared with the lookup table and a sync reset.
`timescale 1ns/1ps
module pxlut_sink
(
    input wire logic i_clk, // Clock
    input wire logic i_rst, // Sync reset
    output logic o_ready // Ready to the table
);
    logic [7:0] lfsr_reg;
    // Stall pattern, ready about three beats in four
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            lfsr_reg <= 8'hA5;
        else
            lfsr_reg <= {lfsr_reg[6:0], lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^ lfsr_reg[3]};
    end
    assign o_ready = lfsr_reg[0] | lfsr_reg[1];
endmodule // pxlut_sink

// File: test/test_pixel_lookup_table.sv
// Self-checking bench for the pixel lookup table.
// Assumes a zero-wait APB slave and the sink model on the output.
`timescale 1ns/1ps
module test_pixel_lookup_table;
    import pxlut_pkg::*;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic pxv_in = 1'b0;
    logic pxr_in;
    pxlut_rgb_s pxd_in = '0;
    logic pxv_out;
    logic pxr_out;
    pxlut_rgb_s pxd_out;
    logic [31:0] rd_data;
    logic rd_err;
    logic en = 1'b0;
    logic [15:0] tab [3][DEPTH];
    logic [13:0] wi [$];
    pxlut_rgb_s exp_q [$];
    int failures = 0;
    int comparisons = 0;
    // ==========
    // Clock, design and far side
    always #5 mclk = ~mclk;
    pxlut_top i_dut (.I_MCLK(mclk), .I_SRST(srst), .I_PSEL(psel), .I_PENABLE(penable),
        .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
        .O_PREADY(pready), .O_PSLVERR(pslverr), .I_PX_VALID(pxv_in), .O_PX_READY(pxr_in),
        .I_PX_DATA(pxd_in), .O_PX_VALID(pxv_out), .I_PX_READY(pxr_out), .O_PX_DATA(pxd_out));
    pxlut_sink i_sink (.i_clk(mclk), .i_rst(srst), .o_ready(pxr_out));
    // ==========
    // Reporting and compares
    task automatic end_sim();
        if (failures == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic fail(input string msg);
        failures++;
        $display("ERROR %0t %s", $time, msg);
    endtask
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
            fail($sformatf("reg got %h exp %h", got, exp));
    endtask
    task automatic chkpx(input pxlut_rgb_s got, input pxlut_rgb_s exp);
        comparisons++;
        if (got !== exp)
            fail($sformatf("pixel got %h exp %h", got, exp));
    endtask
    // Expected pixel: entry per colour from its upper 14 bits, or pass-through
    function automatic pxlut_rgb_s expect_px(input pxlut_rgb_s d);
        pxlut_rgb_s r;
        r = d;
        if (en)
        begin
            r.red = tab[0][d.red[15:2]];
            r.green = tab[1][d.green[15:2]];
            r.blue = tab[2][d.blue[15:2]];
        end
        return r;
    endfunction
    // ==========
    // Bus and stream drivers
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do
            @(posedge mclk);
        while (pready !== 1'b1 && ++n < 50);
        if (pready !== 1'b1)
        begin
            fail("apb timeout");
            end_sim();
        end
        else
        begin
            rd_data = prdata;
            rd_err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk32(rd_data, exp);
    endtask
    task automatic put(input int c, input logic [13:0] i, input logic [15:0] v);
        apb(1'b1, OFS_RED_IDX + 12'(c * 8), {18'h0, i});
        apb(1'b1, OFS_RED_VAL + 12'(c * 8), {16'h0, v});
        tab[c][i] = v;
        wi.push_back(i);
    endtask
    task automatic fill(input logic kind, input logic [15:0] v);
        int n;
        apb(1'b1, OFS_FILL_VAL, {16'h0, v});
        apb(1'b1, OFS_FILL_CMD, {30'h0, kind, 1'b1});
        apb(1'b1, OFS_FILL_CMD, {30'h0, kind, 1'b1});
        rd(OFS_STATUS, 32'h3);
        apb(1'b1, OFS_FILL_CMD, 32'h4);
        for (n = 0; n < 12000; n++)
        begin
            apb(1'b0, OFS_STATUS, 32'h0);
            if (rd_data[ST_BUSY_BIT] === 1'b0)
                break;
        end
        if (n == 12000)
        begin
            fail("fill timeout");
            end_sim();
        end
        else
        begin
            foreach (tab[c, i])
                tab[c][i] = v;
        end
    endtask
    task automatic send(input int n, input bit pick);
        pxlut_rgb_s d;
        int m;
        @(posedge mclk);
        for (int k = 0; k < n; k++)
        begin
            d = 48'({$urandom, $urandom});
            if (pick)
            begin
                d.red[15:2] = wi[$urandom_range(wi.size() - 1)];
                d.green[15:2] = wi[$urandom_range(wi.size() - 1)];
                d.blue[15:2] = wi[$urandom_range(wi.size() - 1)];
            end
            pxv_in <= 1'b1;
            pxd_in <= d;
            m = 0;
            do
                @(posedge mclk);
            while (pxr_in !== 1'b1 && ++m < 50);
            if (pxr_in !== 1'b1)
                fail("pixel timeout");
            exp_q.push_back(expect_px(d));
        end
        pxv_in <= 1'b0;
        for (m = 0; m < 200 && exp_q.size() > 0; m++)
            @(posedge mclk);
        if (exp_q.size() > 0)
            fail("drain timeout");
    endtask
    // Output monitor
    always @(posedge mclk)
    begin
        if (!srst && pxv_out === 1'b1 && pxr_out === 1'b1)
        begin
            if (exp_q.size() == 0)
                fail("unexpected pixel");
            else
                chkpx(pxd_out, exp_q.pop_front());
        end
    end
    // ==========
    // Main sequence
    initial
    begin
        void'($urandom(32'h9264));
        repeat (20) @(posedge mclk);
        srst <= 1'b0;
        rd(OFS_CTRL, 32'h0);
        rd(OFS_STATUS, 32'h0);
        apb(1'b0, 12'h028, 32'h0);
        chk32({rd_err, rd_data[30:0]}, 32'h80000000);
        send(24, 1'b0);
        fill(1'b0, 16'($urandom));
        apb(1'b1, OFS_FILL_CMD, 32'h3);
        rd(OFS_STATUS, 32'h2);
        apb(1'b1, OFS_FILL_CMD, 32'h7);
        rd(OFS_STATUS, 32'h2);
        apb(1'b1, OFS_FILL_CMD, 32'h4);
        rd(OFS_STATUS, 32'h0);
        for (int c = 0; c < 3; c++)
        begin
            put(c, 14'h0000, 16'hFFFF);
            put(c, 14'h3FFF, 16'h0000);
            repeat (4) put(c, 14'($urandom), 16'($urandom));
            put(c, wi[wi.size() - 1], 16'($urandom));
            rd(OFS_RED_VAL + 12'(c * 8), {16'h0, tab[c][wi[wi.size() - 1]]});
        end
        apb(1'b1, OFS_CTRL, 32'h1);
        en = 1'b1;
        send(40, 1'b1);
        send(20, 1'b0);
        apb(1'b1, OFS_CTRL, 32'h3);
        put(1, 14'h0005, 16'h1234);
        send(10, 1'b1);
        fill(1'b1, 16'($urandom));
        send(20, 1'b1);
        end_sim();
    end
endmodule // test_pixel_lookup_table
bind pxlut_top pxlut_chk i_chk (.I_MCLK(I_MCLK), .I_SRST(I_SRST), .I_PSEL(I_PSEL),
    .I_PENABLE(I_PENABLE), .I_PADDR(I_PADDR), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
    .I_PX_VALID(I_PX_VALID), .O_PX_READY(O_PX_READY), .O_PX_VALID(O_PX_VALID),
    .I_PX_READY(I_PX_READY), .O_PX_DATA(O_PX_DATA));
